// ---- design/status_flags_pkg.sv ----
// Package: command codes, bit positions and reset values of the status flag bank
`default_nettype none
package status_flags_pkg;
  // Command codes of the status registers
  localparam logic [7:0] CMD_INPUT_FAULT_FLAGS = 8'h7c;
  localparam logic [7:0] CMD_TEMPERATURE_FAULT_FLAGS = 8'h7d;
  localparam logic [7:0] CMD_COMM_LOGIC_MEMORY_FLAGS = 8'h7e;
  localparam logic [7:0] CMD_ALERT_ORDER_FLAGS = 8'h7f;
  localparam logic [7:0] CMD_VENDOR_FAULT_FLAGS = 8'h80;

  // Input register bits
  localparam int BIT_INPUT_OVERVOLTAGE = 7;
  localparam int BIT_INPUT_UNDERVOLTAGE = 3;
  // Temperature register bits
  localparam int BIT_OVERTEMP_FAULT = 7;
  localparam int BIT_OVERTEMP_WARNING = 6;
  // Communication, logic and memory register bits
  localparam int BIT_INVALID_COMMAND = 7;
  localparam int BIT_INVALID_DATA = 6;
  localparam int BIT_PACKET_CHECK = 5;
  localparam int BIT_MEMORY_ERROR = 4;
  localparam int BIT_OTHER_COMM = 1;
  // Alert order register bit
  localparam int BIT_FIRST_ALERTER = 0;
  // Vendor register bits
  localparam int BIT_DISCONTINUOUS = 7;
  localparam int BIT_CONTROLLER_SHUTDOWN = 6;
  localparam int BIT_POWER_STAGE_FAULT = 5;
  localparam int BIT_STAGE_COMM_WARNING = 4;
  localparam int BIT_STAGE_OVERTEMP = 1;
  localparam int BIT_STAGE_UNDERVOLTAGE = 0;

  // Supported (latched, write-one-to-clear) positions per register
  localparam logic [7:0] MASK_INPUT = 8'h88;
  localparam logic [7:0] MASK_TEMPERATURE = 8'hc0;
  localparam logic [7:0] MASK_COMM = 8'hf2;
  localparam logic [7:0] MASK_ALERT_ORDER = 8'h01;
  localparam logic [7:0] MASK_VENDOR_LATCHED = 8'h73;

  // Value of every flag byte after reset
  localparam logic [7:0] FLAGS_RESET = 8'h00;
endpackage : status_flags_pkg
`default_nettype wire

// ---- design/status_flag_bank.sv ----
// Latched fault and warning flag bank with a link-clock command port and alert line
`default_nettype none
// Operation
// RULE1: A set flag stays set after its cause ends until a clearing action.
// RULE2: Clear-all command or output turn-on clears flags; writing one clears that bit.
// RULE3: Alert mask never touches flags; a disable bit blocks flag and fault response.
// RULE4: Input bit 7 latches input overvoltage, write-one-to-clear, resets to zero.
// RULE5: Low-input bit 3 neither latches nor alerts until supply first crosses turn-on.
// RULE6: Low-input bit reads 0 above turn-on and 1 below turn-off.
// RULE7: Unsupported positions read zero and ignore writes.
// RULE8: Temperature bits 7 and 6 latch overtemperature fault and warning, write-one-to-clear.
// RULE9: Comm bits 7 and 6 latch invalid command and invalid data.
// RULE10: Comm bit 5 latches a packet error check failure.
// RULE11: Comm bit 4 latches any store, restore or programming memory failure.
// RULE12: Memory flag cannot be cleared while the memory problem persists.
// RULE13: Comm bit 1 latches any other communication error, write-one-to-clear.
// RULE14: Comm summary bit is the OR of supported comm flags, immediately.
// RULE15: Clearing comm flags by writes also clears the summary bit.
// RULE16: First-alerter bit 0 never drives alert itself; write-one-to-clear, resets zero.
// RULE17: First-alerter sets only when we assert alert on a line not already low.
// RULE18: Vendor bit 7 is live discontinuous conduction, no alert, no summary.
// RULE19: Vendor bit 5 latches power-stage faults from driver, thermal or input lockout.
// RULE20: Each register is one byte read or written at its command code.
module status_flag_bank
  import status_flags_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic ce,
  // Link-side command port
  input wire logic link_clk,
  input wire logic link_req,
  input wire logic link_write,
  input wire logic [7:0] link_cmd,
  input wire logic [7:0] link_wdata,
  output logic link_busy,
  output logic link_done,
  output logic link_hit,
  output logic [7:0] link_rdata,
  // Fault sources from the converter logic
  input wire logic input_overvoltage_evt,
  input wire logic power_input_above_on,
  input wire logic power_input_below_off,
  input wire logic programmable_overtemp_fault,
  input wire logic programmable_overtemp_warning,
  input wire logic invalid_command_evt,
  input wire logic invalid_data_evt,
  input wire logic packet_check_fail_evt,
  input wire logic memory_error_evt,
  input wire logic memory_error_persists,
  input wire logic other_comm_error_evt,
  input wire logic discontinuous_conduction_live,
  input wire logic controller_shutdown_evt,
  input wire logic driver_supply_undervoltage,
  input wire logic power_stage_overtemp,
  input wire logic power_input_lockout,
  input wire logic stage_comm_warning_evt,
  input wire logic stage_undervoltage_evt,
  // Clearing actions and configuration
  input wire logic clear_faults,
  input wire logic output_turn_on,
  input wire logic [7:0] input_disable,
  input wire logic [7:0] temperature_disable,
  input wire logic [7:0] vendor_disable,
  input wire logic [7:0] input_alert_mask,
  input wire logic [7:0] temperature_alert_mask,
  input wire logic [7:0] comm_alert_mask,
  input wire logic [7:0] vendor_alert_mask,
  // Alert line, open drain
  input wire logic alert_line_in,
  output logic alert_line_out,
  output logic alert_line_oe,
  // Summary bits for the status byte and fault response outputs
  output logic summary_input,
  output logic summary_temperature,
  output logic summary_comm,
  output logic summary_other,
  output logic summary_vendor,
  output logic fault_input_overvoltage,
  output logic fault_overtemp
);

  // System-domain state.
  // The request toggle from the link side passes two flops before use;
  // the command, write flag and data words are read directly, which is
  // safe because the link side holds them until the answer returns.
  typedef struct packed {
    // Two-flop synchroniser of the link request toggle
    logic req_s1;
    logic req_s2;
    // Last toggle level acted on
    logic req_seen;
    // Answer toggle, flipped once per request served
    logic ack_toggle;
    // Answer words, held until the next request
    logic [7:0] rdata;
    logic hit;
    // Latched flag bytes, unsupported positions kept at zero
    logic [7:0] input_flags;
    // Set once the supply has first passed the turn-on level
    logic low_armed;
    logic [7:0] temp_flags;
    logic [7:0] comm_flags;
    logic [7:0] order_flags;
    logic [7:0] vendor_flags;
    // Two-flop synchroniser of the alert wire level
    logic line_s1;
    logic line_s2;
    // Registered alert, drives the open-drain enable
    logic alert;
  } sys_state_type;

  // Link-domain state.
  // Reset is brought over through two flops, so a request can never be
  // taken while the system side still holds its toggles at zero.
  typedef struct packed {
    // Two-flop synchroniser of the system reset
    logic rst_s1;
    logic rst_s2;
    // Request toggle, flipped once per request taken
    logic req_toggle;
    // Two-flop synchroniser of the answer toggle
    logic ack_s1;
    logic ack_s2;
    logic ack_seen;
    // One request outstanding at most
    logic busy;
    // One-cycle answer strobe
    logic done;
    // Request words, held stable for the system side while busy
    logic write;
    logic [7:0] cmd;
    logic [7:0] wdata;
    // Answer words, valid from one done strobe to the next
    logic hit_out;
    logic [7:0] rdata;
  } link_state_type;

  sys_state_type sys_q, sys_d;
  link_state_type link_q, link_d;

  // Latched flag update: a set in the same cycle as a clear wins
  function automatic logic [7:0] latch_flags(input logic [7:0] q, input logic [7:0] set,
                                            input logic [7:0] clr, input logic [7:0] mask);
    latch_flags = ((q & ~clr) | set) & mask; // [RULE1] [RULE7]
  endfunction

  function automatic logic cmd_hit(input logic [7:0] cmd);
    cmd_hit = (cmd == CMD_INPUT_FAULT_FLAGS) || (cmd == CMD_TEMPERATURE_FAULT_FLAGS) ||
              (cmd == CMD_COMM_LOGIC_MEMORY_FLAGS) || (cmd == CMD_ALERT_ORDER_FLAGS) ||
              (cmd == CMD_VENDOR_FAULT_FLAGS);
  endfunction

  // System clock domain.
  // Every flag follows one pattern: set terms of the input, temperature and
  // vendor flags are gated by the disable bits, clear terms come from clear-all
  // or a write of ones, and a set in the same cycle as its clear wins so no event is lost.
  logic [7:0] in_set, tmp_set, cml_set, ven_set;
  logic [7:0] in_clr, tmp_clr, cml_clr, ord_clr, ven_clr;
  logic [7:0] wclr;
  logic new_req, wr_op, clr_all;
  logic [7:0] in_read, ven_read, rd_byte;
  logic alert_now;

  always_comb begin
    sys_d = sys_q;
    new_req = sys_q.req_s2 != sys_q.req_seen;
    wr_op = new_req && link_q.write;
    clr_all = clear_faults || output_turn_on; // [RULE2]
    wclr = link_q.wdata;

    in_set = 8'h00;
    in_set[BIT_INPUT_OVERVOLTAGE] = input_overvoltage_evt;
    in_set[BIT_INPUT_UNDERVOLTAGE] = sys_q.low_armed && power_input_below_off; // [RULE5]
    in_set = in_set & ~input_disable; // [RULE3]
    tmp_set = 8'h00;
    tmp_set[BIT_OVERTEMP_FAULT] = programmable_overtemp_fault; // [RULE8]
    tmp_set[BIT_OVERTEMP_WARNING] = programmable_overtemp_warning; // [RULE8]
    tmp_set = tmp_set & ~temperature_disable; // [RULE3]
    cml_set = 8'h00;
    cml_set[BIT_INVALID_COMMAND] = invalid_command_evt; // [RULE9]
    cml_set[BIT_INVALID_DATA] = invalid_data_evt; // [RULE9]
    cml_set[BIT_PACKET_CHECK] = packet_check_fail_evt; // [RULE10]
    cml_set[BIT_MEMORY_ERROR] = memory_error_evt; // [RULE11]
    cml_set[BIT_OTHER_COMM] = other_comm_error_evt; // [RULE13]
    ven_set = 8'h00;
    ven_set[BIT_CONTROLLER_SHUTDOWN] = controller_shutdown_evt;
    ven_set[BIT_POWER_STAGE_FAULT] = driver_supply_undervoltage || power_stage_overtemp ||
                                     power_input_lockout; // [RULE19]
    ven_set[BIT_STAGE_COMM_WARNING] = stage_comm_warning_evt;
    ven_set[BIT_STAGE_OVERTEMP] = power_stage_overtemp;
    ven_set[BIT_STAGE_UNDERVOLTAGE] = stage_undervoltage_evt;
    ven_set = ven_set & ~vendor_disable; // [RULE3]

    // Clear masks: clear-all or a write of ones at the register's code
    in_clr = clr_all ? 8'hff : ((wr_op && link_q.cmd == CMD_INPUT_FAULT_FLAGS) ? wclr : 8'h00); // [RULE2]
    tmp_clr = clr_all ? 8'hff : ((wr_op && link_q.cmd == CMD_TEMPERATURE_FAULT_FLAGS) ? wclr : 8'h00);
    cml_clr = clr_all ? 8'hff : ((wr_op && link_q.cmd == CMD_COMM_LOGIC_MEMORY_FLAGS) ? wclr : 8'h00);
    ord_clr = clr_all ? 8'hff : ((wr_op && link_q.cmd == CMD_ALERT_ORDER_FLAGS) ? wclr : 8'h00);
    ven_clr = clr_all ? 8'hff : ((wr_op && link_q.cmd == CMD_VENDOR_FAULT_FLAGS) ? wclr : 8'h00);
    if (memory_error_persists) begin
      cml_clr[BIT_MEMORY_ERROR] = 1'b0; // [RULE12]
    end

    // Arm the low-input latch once the supply first passes the turn-on level
    if (power_input_above_on) begin
      sys_d.low_armed = 1'b1; // [RULE5]
    end

    // Alert from any unmasked latched flag; the first-alerter bit does not count.
    // The alert masks act here only, never on the flags themselves.
    alert_now = |(sys_q.input_flags & ~input_alert_mask) || |(sys_q.temp_flags & ~temperature_alert_mask) ||
                |(sys_q.comm_flags & ~comm_alert_mask) ||
                |(sys_q.vendor_flags & MASK_VENDOR_LATCHED & ~vendor_alert_mask); // [RULE16] [RULE18]
    sys_d.alert = alert_now;
    sys_d.line_s1 = alert_line_in;
    sys_d.line_s2 = sys_q.line_s1;

    sys_d.input_flags = latch_flags(sys_q.input_flags, in_set, in_clr, MASK_INPUT); // [RULE4]
    sys_d.temp_flags = latch_flags(sys_q.temp_flags, tmp_set, tmp_clr, MASK_TEMPERATURE);
    sys_d.comm_flags = latch_flags(sys_q.comm_flags, cml_set, cml_clr, MASK_COMM); // [RULE15]
    sys_d.order_flags = latch_flags(sys_q.order_flags,
                                    {7'h00, alert_now && !sys_q.alert && sys_q.line_s2}, // [RULE17]
                                    ord_clr, MASK_ALERT_ORDER);
    sys_d.vendor_flags = latch_flags(sys_q.vendor_flags, ven_set, ven_clr, MASK_VENDOR_LATCHED);

    // Read view: low-input bit shows the live level before arming
    in_read = sys_q.input_flags;
    in_read[BIT_INPUT_UNDERVOLTAGE] = sys_q.input_flags[BIT_INPUT_UNDERVOLTAGE] ||
                                      (!sys_q.low_armed && power_input_below_off &&
                                       !input_disable[BIT_INPUT_UNDERVOLTAGE]); // [RULE6]
    ven_read = sys_q.vendor_flags;
    ven_read[BIT_DISCONTINUOUS] = discontinuous_conduction_live; // [RULE18]
    case (link_q.cmd)
      CMD_INPUT_FAULT_FLAGS: rd_byte = in_read;
      CMD_TEMPERATURE_FAULT_FLAGS: rd_byte = sys_q.temp_flags;
      CMD_COMM_LOGIC_MEMORY_FLAGS: rd_byte = sys_q.comm_flags;
      CMD_ALERT_ORDER_FLAGS: rd_byte = sys_q.order_flags;
      CMD_VENDOR_FAULT_FLAGS: rd_byte = ven_read;
      default: rd_byte = 8'h00; // [RULE7]
    endcase

    // Request handshake from the link domain.
    // A new request is served once, on the edge where the synchronised
    // toggle first differs from the last one seen; the answer words are
    // loaded on the same edge that flips the answer toggle, so the link side always sees
    // them settled when its own synchronised copy changes.
    sys_d.req_s1 = link_q.req_toggle;
    sys_d.req_s2 = sys_q.req_s1;
    if (new_req) begin
      sys_d.req_seen = sys_q.req_s2;
      sys_d.rdata = link_q.write ? 8'h00 : rd_byte; // [RULE20]
      sys_d.hit = cmd_hit(link_q.cmd);
      sys_d.ack_toggle = !sys_q.ack_toggle;
    end
  end

  // Reset acts whatever the clock enable; the alert wire sync starts at
  // the idle (high) level so no false first-alerter edge follows reset.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sys_q <= '0;
      sys_q.input_flags <= FLAGS_RESET;
      sys_q.temp_flags <= FLAGS_RESET;
      sys_q.comm_flags <= FLAGS_RESET;
      sys_q.order_flags <= FLAGS_RESET;
      sys_q.vendor_flags <= FLAGS_RESET;
      sys_q.line_s1 <= 1'b1;
      sys_q.line_s2 <= 1'b1;
    end else if (ce) begin
      sys_q <= sys_d;
    end
  end

  assign alert_line_out = 1'b0;
  assign alert_line_oe = sys_q.alert;
  assign summary_input = |sys_q.input_flags;
  assign summary_temperature = |sys_q.temp_flags;
  assign summary_comm = |sys_q.comm_flags; // [RULE14] [RULE15]
  assign summary_other = |sys_q.order_flags;
  assign summary_vendor = |(sys_q.vendor_flags & MASK_VENDOR_LATCHED); // [RULE18]
  // Fault responses follow the latched, disable-gated flags
  assign fault_input_overvoltage = sys_q.input_flags[BIT_INPUT_OVERVOLTAGE]; // [RULE3]
  assign fault_overtemp = sys_q.temp_flags[BIT_OVERTEMP_FAULT]; // [RULE3]

  // Link clock domain.
  // The answer toggle from the system side passes two flops; the answer
  // words are read directly once it changes, as they are held until the
  // next request. The local reset keeps busy low in the state itself and
  // the port shows busy through the reset flop, so the port is free again
  // as soon as the synchronised reset falls.
  logic link_rst, ack_new;

  always_comb begin
    link_d = link_q;
    link_d.rst_s1 = srst;
    link_d.rst_s2 = link_q.rst_s1;
    link_rst = link_q.rst_s2;
    link_d.ack_s1 = sys_q.ack_toggle;
    link_d.ack_s2 = link_q.ack_s1;
    ack_new = link_q.ack_s2 != link_q.ack_seen;
    link_d.done = 1'b0;
    if (link_q.busy && ack_new) begin
      link_d.ack_seen = link_q.ack_s2;
      link_d.busy = 1'b0;
      link_d.done = 1'b1;
      link_d.rdata = sys_q.rdata; // [RULE20]
      link_d.hit_out = sys_q.hit;
    end else if (!link_q.busy && link_req) begin
      // Command and data stay held until the answer returns
      link_d.busy = 1'b1;
      link_d.write = link_write;
      link_d.cmd = link_cmd;
      link_d.wdata = link_wdata;
      link_d.req_toggle = !link_q.req_toggle;
    end
    if (link_rst) begin
      link_d = '0;
      link_d.rst_s1 = srst;
      link_d.rst_s2 = link_q.rst_s1;
    end
  end

  // No clock enable here: the link side must keep answering its reset
  always_ff @(posedge link_clk) begin
    link_q <= link_d;
  end

  // Busy during local reset so no request is taken before the handshake is quiet
  assign link_busy = link_q.busy || link_rst;
  assign link_done = link_q.done;
  assign link_hit = link_q.hit_out;
  assign link_rdata = link_q.rdata;

endmodule // status_flag_bank
`default_nettype wire

// ---- sim/status_flag_bank_sva.sv ----
// Concurrent checks on the status flag bank ports
`default_nettype none
module status_flag_bank_sva
  import status_flags_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic ce,
  input wire logic link_clk,
  input wire logic link_busy,
  input wire logic link_done,
  input wire logic input_overvoltage_evt,
  input wire logic power_input_below_off,
  input wire logic clear_faults,
  input wire logic output_turn_on,
  input wire logic [7:0] input_disable,
  input wire logic alert_line_oe,
  input wire logic summary_input,
  input wire logic summary_temperature,
  input wire logic summary_comm,
  input wire logic summary_other,
  input wire logic summary_vendor,
  input wire logic fault_input_overvoltage
);
  a_ovp_sets: assert property (@(posedge clk_sys) disable iff (srst)
    ce && input_overvoltage_evt && !input_disable[7] |=> fault_input_overvoltage && summary_input)
    else $error("overvoltage flag not latched");
  a_ovp_holds: assert property (@(posedge clk_sys) disable iff (srst)
    fault_input_overvoltage && !clear_faults && !output_turn_on && !link_busy |=> fault_input_overvoltage)
    else $error("overvoltage flag dropped without a clear");
  a_disable_blocks: assert property (@(posedge clk_sys) disable iff (srst)
    input_disable[7] && !fault_input_overvoltage |=> !fault_input_overvoltage)
    else $error("disabled overvoltage flag was set");
  a_clear_all: assert property (@(posedge clk_sys) disable iff (srst)
    ce && (clear_faults || output_turn_on) && !input_overvoltage_evt && !power_input_below_off
    ##1 !power_input_below_off |-> !summary_input)
    else $error("input flags survived a clear-all");
  a_first_src: assert property (@(posedge clk_sys) disable iff (srst)
    $rose(summary_other) |-> $rose(alert_line_oe))
    else $error("first alerter set without own alert rising");
  a_alert_quiet: assert property (@(posedge clk_sys) disable iff (srst)
    ce && !summary_input && !summary_temperature && !summary_comm && !summary_vendor |=> !alert_line_oe)
    else $error("alert driven with no fault flag");
  a_done_single: assert property (@(posedge link_clk) disable iff (srst)
    link_done |=> !link_done)
    else $error("done pulse longer than one cycle");
  a_answer_bound: assert property (@(posedge link_clk) disable iff (srst)
    $rose(link_busy) |-> ##[1:12] link_done)
    else $error("link request not answered");
  c_first: cover property (@(posedge clk_sys) $rose(summary_other));
  c_clear: cover property (@(posedge clk_sys) clear_faults && summary_input);
  c_done: cover property (@(posedge link_clk) link_done);
endmodule // status_flag_bank_sva
bind status_flag_bank status_flag_bank_sva chk (.*);
`default_nettype wire

// ---- sim/link_host_model.sv ----
// Host model issuing single-byte reads and clears on the link port
`default_nettype none
module link_host_model (
  input wire logic link_clk,
  input wire logic link_busy,
  input wire logic link_done,
  input wire logic link_hit,
  input wire logic [7:0] link_rdata,
  output logic link_req = 1'b0,
  output logic link_write = 1'b0,
  output logic [7:0] link_cmd = 8'h00,
  output logic [7:0] link_wdata = 8'h00
);
  timeunit 1ns;
  timeprecision 1ps;
  // One byte per transfer, one outstanding request
  task automatic xfer(input logic wr, input logic [7:0] cmd, input logic [7:0] wd,
                      output logic [7:0] rd, output logic hit);
    int n;
    n = 0;
    rd = 8'hxx;
    hit = 1'bx;
    @(posedge link_clk);
    while (link_busy) @(posedge link_clk);
    link_req <= 1'b1;
    link_write <= wr;
    link_cmd <= cmd;
    link_wdata <= wd;
    @(posedge link_clk);
    // Released command and data lines show the inverse so stale values never pass
    link_req <= 1'b0;
    link_cmd <= ~cmd;
    link_wdata <= ~wd;
    while (!link_done && n < 64) begin
      @(posedge link_clk);
      n++;
    end
    if (link_done) begin
      rd = link_rdata;
      hit = link_hit;
    end
  endtask
endmodule // link_host_model
`default_nettype wire

// ---- sim/status_flag_bank_tb_top.sv ----
// Self-checking bench of the status flag bank
`default_nettype none
module status_flag_bank_tb_top import status_flags_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic link_clk = 1'b0;
  logic srst = 1'b1;
  logic ce = 1'b1;
  logic above_on = 1'b0;
  logic below_off = 1'b0;
  logic other_low = 1'b0;
  logic [17:0] ev = 18'h00000;
  logic [7:0] dis_in = 8'h00;
  logic [7:0] mask = 8'hff;
  logic link_req, link_write, link_busy, link_done, link_hit, alert_line_oe, fault_ovp, hit, line;
  logic [7:0] link_cmd, link_wdata, link_rdata, rd;
  logic [4:0] summ;
  logic fault_ot;
  int num_errors = 0;
  int n_tests = 0;
  logic [23:0] rows [14] = '{24'h007c80, 24'h017d80, 24'h027d40, 24'h037e80, 24'h047e40, 24'h057e20, 24'h067e10,
    24'h077e02, 24'h088040, 24'h098020, 24'h0a8022, 24'h0b8020, 24'h0c8010, 24'h0d8001};
  assign line = !(alert_line_oe || other_low);
  always #50 clk_sys = ~clk_sys;
  always #62.5 link_clk = ~link_clk;
  status_flag_bank dut (.clk_sys(clk_sys), .srst(srst), .ce(ce), .link_clk(link_clk), .link_req(link_req),
    .link_write(link_write), .link_cmd(link_cmd), .link_wdata(link_wdata), .link_busy(link_busy),
    .link_done(link_done), .link_hit(link_hit), .link_rdata(link_rdata), .input_overvoltage_evt(ev[0]),
    .power_input_above_on(above_on), .power_input_below_off(below_off), .programmable_overtemp_fault(ev[1]),
    .programmable_overtemp_warning(ev[2]), .invalid_command_evt(ev[3]), .invalid_data_evt(ev[4]),
    .packet_check_fail_evt(ev[5]), .memory_error_evt(ev[6]), .memory_error_persists(ev[15]),
    .other_comm_error_evt(ev[7]), .discontinuous_conduction_live(ev[14]), .controller_shutdown_evt(ev[8]),
    .driver_supply_undervoltage(ev[9]), .power_stage_overtemp(ev[10]), .power_input_lockout(ev[11]),
    .stage_comm_warning_evt(ev[12]), .stage_undervoltage_evt(ev[13]), .clear_faults(ev[16]),
    .output_turn_on(ev[17]), .input_disable(dis_in), .temperature_disable(8'h00), .vendor_disable(8'h00),
    .input_alert_mask(mask), .temperature_alert_mask(mask), .comm_alert_mask(mask), .vendor_alert_mask(mask),
    .alert_line_in(line), .alert_line_out(), .alert_line_oe(alert_line_oe), .summary_input(summ[0]),
    .summary_temperature(summ[1]), .summary_comm(summ[2]), .summary_other(summ[3]), .summary_vendor(summ[4]),
    .fault_input_overvoltage(fault_ovp), .fault_overtemp(fault_ot));
  link_host_model host (.link_clk(link_clk), .link_busy(link_busy), .link_done(link_done), .link_hit(link_hit),
    .link_rdata(link_rdata), .link_req(link_req), .link_write(link_write), .link_cmd(link_cmd),
    .link_wdata(link_wdata));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rd_chk(input logic [7:0] cmd, input logic [7:0] exp);
    host.xfer(1'b0, cmd, 8'h00, rd, hit);
    check(rd, exp);
  endtask
  task automatic wr(input logic [7:0] cmd, input logic [7:0] d);
    host.xfer(1'b1, cmd, d, rd, hit);
  endtask
  task automatic pulse(input int i);
    @(posedge clk_sys) ev[i] <= 1'b1;
    @(posedge clk_sys) ev[i] <= 1'b0;
    #1;
  endtask
  task automatic end_sim();
    $display("errors %0d checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge clk_sys);
    num_errors++;
    end_sim();
  end
  initial begin
    repeat (20) @(posedge clk_sys);
    srst <= 1'b0;
    // Alerts masked: flags must still latch
    foreach (rows[k]) begin
      pulse(int'(rows[k][23:16]));
      rd_chk(rows[k][15:8], rows[k][7:0]);
      wr(rows[k][15:8], 8'hff);
      rd_chk(rows[k][15:8], 8'h00);
    end
    @(posedge clk_sys) {mask, below_off} <= {8'h00, 1'b1};
    rd_chk(CMD_INPUT_FAULT_FLAGS, 8'h08);
    check({7'h00, alert_line_oe}, 8'h00);
    @(posedge clk_sys) below_off <= 1'b0;
    rd_chk(CMD_INPUT_FAULT_FLAGS, 8'h00);
    @(posedge clk_sys) above_on <= 1'b1;
    @(posedge clk_sys) {above_on, below_off} <= 2'b01;
    @(posedge clk_sys) below_off <= 1'b0;
    rd_chk(CMD_INPUT_FAULT_FLAGS, 8'h08);
    check({7'h00, alert_line_oe}, 8'h01);
    rd_chk(CMD_ALERT_ORDER_FLAGS, 8'h01);
    wr(CMD_INPUT_FAULT_FLAGS, 8'h08);
    rd_chk(CMD_INPUT_FAULT_FLAGS, 8'h00);
    check({7'h00, alert_line_oe}, 8'h00);
    wr(CMD_ALERT_ORDER_FLAGS, 8'h01);
    rd_chk(CMD_ALERT_ORDER_FLAGS, 8'h00);
    // Another device already holds the line low
    @(posedge clk_sys) other_low <= 1'b1;
    pulse(0);
    rd_chk(CMD_INPUT_FAULT_FLAGS, 8'h80);
    check({7'h00, alert_line_oe}, 8'h01);
    rd_chk(CMD_ALERT_ORDER_FLAGS, 8'h00);
    pulse(16);
    @(posedge clk_sys) other_low <= 1'b0;
    rd_chk(CMD_INPUT_FAULT_FLAGS, 8'h00);
    pulse(1);
    check({7'h00, fault_ot}, 8'h01);
    pulse(17);
    rd_chk(CMD_TEMPERATURE_FAULT_FLAGS, 8'h00);
    pulse(3);
    check({7'h00, summ[2]}, 8'h01);
    wr(CMD_COMM_LOGIC_MEMORY_FLAGS, 8'h80);
    check({7'h00, summ[2]}, 8'h00);
    @(posedge clk_sys) ev[15] <= 1'b1;
    pulse(6);
    pulse(16);
    wr(CMD_COMM_LOGIC_MEMORY_FLAGS, 8'h10);
    rd_chk(CMD_COMM_LOGIC_MEMORY_FLAGS, 8'h10);
    @(posedge clk_sys) ev[15] <= 1'b0;
    wr(CMD_COMM_LOGIC_MEMORY_FLAGS, 8'h10);
    rd_chk(CMD_COMM_LOGIC_MEMORY_FLAGS, 8'h00);
    @(posedge clk_sys) ev[14] <= 1'b1;
    rd_chk(CMD_VENDOR_FAULT_FLAGS, 8'h80);
    check({6'h00, summ[4], alert_line_oe}, 8'h00);
    @(posedge clk_sys) ev[14] <= 1'b0;
    rd_chk(CMD_VENDOR_FAULT_FLAGS, 8'h00);
    @(posedge clk_sys) dis_in <= 8'h80;
    pulse(0);
    rd_chk(CMD_INPUT_FAULT_FLAGS, 8'h00);
    @(posedge clk_sys) {dis_in, ce} <= {8'h00, 1'b0};
    pulse(0);
    @(posedge clk_sys) ce <= 1'b1;
    check({7'h00, fault_ovp}, 8'h00);
    host.xfer(1'b0, 8'h81, 8'h00, rd, hit);
    check({hit, rd[6:0]}, 8'h00);
    pulse(0);
    pulse(1);
    @(posedge clk_sys) srst <= 1'b1;
    repeat (20) @(posedge clk_sys);
    srst <= 1'b0;
    for (int c = 8'h7c; c <= 8'h80; c++) rd_chk(8'(c), 8'h00);
    check({7'h00, alert_line_oe}, 8'h00);
    end_sim();
  end
endmodule // status_flag_bank_tb_top
`default_nettype wire
